// File: ssoh_top.v
// sub-stm-1 multiplex section overhead insert, check and one-second counts
// What this block does
// - transmit s1 bits 5 to 8 as 0000, quality unknown.
// - transmit m1 bits 2 to 8 as received b2 error count 0 to 8.
// - decode received m1 bits 2 to 8; codes above eight mean zero.
// - unidirectional mode sends m1 as all zeros.
// - e2 sent as given; received e2 ignored.
// - receive b2 check: frame parity against next frame's b2 byte.
// - received k1 and k2 bits 1 to 5 ignored.
// - remote defect set after five frames of k2 pattern 110.
// - remote defect cleared after five frames of other k2 patterns.
// - alarm indication set after five frames of k2 pattern 111.
// - alarm indication cleared after five frames differing from 111.
// - remote defect reported only while monitored.
// - unidirectional: no remote defect, m1 ignored, near-end counts only.
// - received s1 bits 5 to 8 and d4 to d12 ignored.
// - per second count frames with any b2 violation.
// - per second count frames with nonzero decoded m1.
// - near defect second when alarm indication seen in the second.
// - far defect second when remote defect seen in the second.
// - while monitored, deliver four counts at each second's close.
// - transmit framing word a1 11110110 then a2 00101000.
// - transmit 16-byte trace, one byte per frame in j0.
// - transmit b2 is even parity of previous frame minus rows 1-3 soh.
// - defects declared and reported only in the monitored state.
`timescale 1ns/1ns
`include "ssoh_defines.vh"
module ssoh_top (
  // clock and reset
  input  wire                  i_clk,
  input  wire                  i_srst,
  // management controls
  input  wire                  i_monitored,
  input  wire                  i_unidir,
  input  wire                  i_sec_tick,
  input  wire [127:0]          i_trail_trace_identifier,
  // transmit stream from the frame data path
  input  wire                  i_tx_valid,
  output wire                  o_tx_ready,
  input  wire [7:0]            i_tx_data,
  input  wire                  i_tx_sof,
  // transmit stream toward scrambler
  output wire                  o_txo_valid,
  input  wire                  i_txo_ready,
  output wire [7:0]            o_txo_data,
  output wire                  o_txo_sof,
  // receive stream, aligned and descrambled
  input  wire                  i_rx_valid,
  input  wire [7:0]            i_rx_data,
  input  wire                  i_rx_sof,
  // defects toward the management function
  output wire                  o_remote_defect,
  output wire                  o_alarm_defect,
  // one-second report
  output reg                   o_pm_valid,
  output reg  [`SSOH_CW-1:0]   o_near_errored_block_count,
  output reg  [`SSOH_CW-1:0]   o_far_errored_block_count,
  output reg                   o_near_defect_second,
  output reg                   o_far_defect_second
);

  // overhead position of a byte from its row and column
  function [3:0] ssoh_pos;
    input [3:0] row;
    input [6:0] col;
    begin
      ssoh_pos = `SSOH_POS_NONE;
      if (col < `SSOH_SOH_COLS) begin
        if (row < `SSOH_RS_ROWS)
          ssoh_pos = `SSOH_POS_RSOH;
        if (row == 4'h0 && col == 7'h00)
          ssoh_pos = `SSOH_POS_A1;
        else if (row == 4'h0 && col == 7'h01)
          ssoh_pos = `SSOH_POS_A2;
        else if (row == 4'h0)
          ssoh_pos = `SSOH_POS_J0;
        else if (row == 4'h4 && col == 7'h00)
          ssoh_pos = `SSOH_POS_B2;
        else if (row == 4'h4 && col == 7'h01)
          ssoh_pos = `SSOH_POS_K1;
        else if (row == 4'h4)
          ssoh_pos = `SSOH_POS_K2;
        else if (row == 4'h8 && col == 7'h00)
          ssoh_pos = `SSOH_POS_S1;
        else if (row == 4'h8 && col == 7'h01)
          ssoh_pos = `SSOH_POS_M1;
        else if (row == 4'h8)
          ssoh_pos = `SSOH_POS_E2;
      end
    end
  endfunction

  // number of set bits in a parity difference
  function [6:0] ssoh_ones;
    input [7:0] v;
    integer k;
    begin
      ssoh_ones = 7'h00;
      for (k = 0; k < 8; k = k + 1)
        ssoh_ones = ssoh_ones + {6'h00, v[k]};
    end
  endfunction

  // ---------------- transmit side ----------------
  reg  [3:0] tx_row_reg;
  reg  [6:0] tx_col_reg;
  reg  [7:0] tx_par_reg;
  reg  [7:0] tx_b2_reg;
  reg  [3:0] tti_idx_reg;
  reg  [6:0] rem_cnt_reg;
  reg  [7:0] tx_byte;
  wire       buf_ready;
  wire       tx_take;
  wire [3:0] tx_row;
  wire [6:0] tx_col;
  wire [3:0] tx_pos;
  wire       tx_last;
  wire [6:0] tti_base;

  assign o_tx_ready = buf_ready;
  assign tx_take    = i_tx_valid & buf_ready;
  assign tx_row     = i_tx_sof ? 4'h0 : tx_row_reg;
  assign tx_col     = i_tx_sof ? 7'h00 : tx_col_reg;
  assign tx_pos     = ssoh_pos(tx_row, tx_col);
  assign tx_last    = (tx_row == `SSOH_LAST_ROW) &&
                      (tx_col == `SSOH_LAST_COL);
  assign tti_base   = {~tti_idx_reg, 3'h0}; // first trace byte from the top

  // overwrite the overhead bytes this block owns
  always @* begin
    tx_byte = i_tx_data;
    case (tx_pos)
      `SSOH_POS_A1: tx_byte = `SSOH_A1_WORD;
      `SSOH_POS_A2: tx_byte = `SSOH_A2_WORD;
      `SSOH_POS_J0: tx_byte = i_trail_trace_identifier[tti_base +: 8];
      `SSOH_POS_B2: tx_byte = tx_b2_reg;
      `SSOH_POS_S1: tx_byte = {i_tx_data[7:4], `SSOH_S1_QL};
      `SSOH_POS_M1: tx_byte = i_unidir ? 8'h00 :
                              {1'b0, rem_cnt_reg};
      `SSOH_POS_E2: tx_byte = i_tx_data;
      default:      tx_byte = i_tx_data;
    endcase
  end

  // position, trace index and outgoing parity
  always @(posedge i_clk) begin
    if (i_srst) begin
      tx_row_reg  <= 4'h0;
      tx_col_reg  <= 7'h00;
      tx_par_reg  <= 8'h00;
      tx_b2_reg   <= 8'h00;
      tti_idx_reg <= 4'h0;
    end else if (tx_take) begin
      if (tx_pos == `SSOH_POS_J0)
        tti_idx_reg <= tti_idx_reg + 4'h1;
      if (tx_last) begin
        tx_row_reg <= 4'h0;
        tx_col_reg <= 7'h00;
        tx_b2_reg  <= tx_par_reg ^ tx_byte;
        tx_par_reg <= 8'h00;
      end else begin
        if (tx_col == `SSOH_LAST_COL) begin
          tx_col_reg <= 7'h00;
          tx_row_reg <= tx_row + 4'h1;
        end else begin
          tx_col_reg <= tx_col + 7'h01;
          tx_row_reg <= tx_row;
        end
        // the section overhead bytes of rows 0 to 2 are left out of the sum
        if (tx_pos != `SSOH_POS_RSOH && tx_pos != `SSOH_POS_A1 &&
            tx_pos != `SSOH_POS_A2 && tx_pos != `SSOH_POS_J0)
          tx_par_reg <= tx_par_reg ^ tx_byte;
      end
    end
  end

  // outgoing words wait here when the scrambler stalls
  ssoh_buf2 u_tx_buf (
    .i_clk   (i_clk),
    .i_srst  (i_srst),
    .i_valid (i_tx_valid),
    .o_ready (buf_ready),
    .i_data  ({i_tx_sof, tx_byte}),
    .o_valid (o_txo_valid),
    .i_ready (i_txo_ready),
    .o_data  ({o_txo_sof, o_txo_data})
  );

  // ---------------- receive side ----------------
  reg  [3:0] rx_row_reg;
  reg  [6:0] rx_col_reg;
  reg  [7:0] rx_par_reg;
  reg  [7:0] rx_prev_reg;
  reg        rx_prev_ok_reg;
  reg        near_evt_reg;
  reg        far_evt_reg;
  wire [3:0] rx_row;
  wire [6:0] rx_col;
  wire [3:0] rx_pos;
  wire       rx_last;
  wire       rx_inpar;
  wire [6:0] b2_errs;
  wire [6:0] m1_code;
  wire       k2_frame;
  wire       rdi_raw;
  wire       ais_raw;

  assign rx_row   = i_rx_sof ? 4'h0 : rx_row_reg;
  assign rx_col   = i_rx_sof ? 7'h00 : rx_col_reg;
  assign rx_pos   = ssoh_pos(rx_row, rx_col);
  assign rx_last  = (rx_row == `SSOH_LAST_ROW) &&
                    (rx_col == `SSOH_LAST_COL);
  assign rx_inpar = (rx_pos != `SSOH_POS_RSOH) &&
                    (rx_pos != `SSOH_POS_A1) &&
                    (rx_pos != `SSOH_POS_A2) &&
                    (rx_pos != `SSOH_POS_J0);
  assign b2_errs  = ssoh_ones(i_rx_data ^ rx_prev_reg);
  assign m1_code  = i_rx_data[6:0];
  // besides b2 and m1, only k2 bits 6 to 8 are looked at; k1, s1, e2, d4-d12 are not
  assign k2_frame = i_rx_valid && (rx_pos == `SSOH_POS_K2);

  // receive position, parity and per-frame error events
  always @(posedge i_clk) begin
    if (i_srst) begin
      rx_row_reg     <= 4'h0;
      rx_col_reg     <= 7'h00;
      rx_par_reg     <= 8'h00;
      rx_prev_reg    <= 8'h00;
      rx_prev_ok_reg <= 1'b0;
      rem_cnt_reg    <= 7'h00;
      near_evt_reg   <= 1'b0;
      far_evt_reg    <= 1'b0;
    end else begin
      near_evt_reg <= 1'b0;
      far_evt_reg  <= 1'b0;
      if (i_rx_valid) begin
        if (rx_last) begin
          rx_row_reg     <= 4'h0;
          rx_col_reg     <= 7'h00;
          rx_prev_reg    <= rx_par_reg ^ i_rx_data;
          rx_prev_ok_reg <= 1'b1;
          rx_par_reg     <= 8'h00;
        end else begin
          if (rx_col == `SSOH_LAST_COL) begin
            rx_col_reg <= 7'h00;
            rx_row_reg <= rx_row + 4'h1;
          end else begin
            rx_col_reg <= rx_col + 7'h01;
            rx_row_reg <= rx_row;
          end
          if (rx_inpar)
            rx_par_reg <= rx_par_reg ^ i_rx_data;
        end
        // first frame after reset has nothing to compare against
        if (rx_pos == `SSOH_POS_B2 && rx_prev_ok_reg) begin
          rem_cnt_reg  <= b2_errs;
          near_evt_reg <= (b2_errs != 7'h00);
        end
        // far-end count ignored entirely in unidirectional mode
        if (rx_pos == `SSOH_POS_M1 && !i_unidir)
          far_evt_reg <= (m1_code != 7'h00) &&
                         (m1_code <= `SSOH_REI_MAX);
      end
    end
  end

  // ---------------- defect filters ----------------
  // filters held clear while unmonitored so nothing is declared
  wire rdi_clr;
  wire ais_clr;

  assign rdi_clr = ~i_monitored | i_unidir;
  assign ais_clr = ~i_monitored;

  ssoh_persist u_rdi (
    .i_clk    (i_clk),
    .i_srst   (i_srst),
    .i_clr    (rdi_clr),
    .i_frame  (k2_frame),
    .i_match  (i_rx_data[2:0] == `SSOH_RDI_CODE),
    .o_defect (rdi_raw)
  );

  ssoh_persist u_ais (
    .i_clk    (i_clk),
    .i_srst   (i_srst),
    .i_clr    (ais_clr),
    .i_frame  (k2_frame),
    .i_match  (i_rx_data[2:0] == `SSOH_AIS_CODE),
    .o_defect (ais_raw)
  );

  assign o_remote_defect = rdi_raw & i_monitored;
  assign o_alarm_defect  = ais_raw & i_monitored;

  // ---------------- one-second counters ----------------
  reg  [`SSOH_CW-1:0] near_cnt_reg;
  reg  [`SSOH_CW-1:0] far_cnt_reg;
  reg                 near_ds_reg;
  reg                 far_ds_reg;
  wire [`SSOH_CW-1:0] near_inc;
  wire [`SSOH_CW-1:0] far_inc;

  assign near_inc = {{(`SSOH_CW-1){1'b0}}, near_evt_reg};
  assign far_inc  = {{(`SSOH_CW-1){1'b0}}, far_evt_reg};

  // the event of the closing cycle is counted in the closing second
  always @(posedge i_clk) begin
    if (i_srst) begin
      near_cnt_reg               <= {`SSOH_CW{1'b0}};
      far_cnt_reg                <= {`SSOH_CW{1'b0}};
      near_ds_reg                <= 1'b0;
      far_ds_reg                 <= 1'b0;
      o_pm_valid                 <= 1'b0;
      o_near_errored_block_count <= {`SSOH_CW{1'b0}};
      o_far_errored_block_count  <= {`SSOH_CW{1'b0}};
      o_near_defect_second       <= 1'b0;
      o_far_defect_second        <= 1'b0;
    end else if (i_sec_tick) begin
      near_cnt_reg <= {`SSOH_CW{1'b0}};
      far_cnt_reg  <= {`SSOH_CW{1'b0}};
      near_ds_reg  <= ais_raw; // a standing defect marks the new second
      far_ds_reg   <= rdi_raw;
      o_pm_valid   <= i_monitored;
      if (i_monitored) begin
        o_near_errored_block_count <= near_cnt_reg + near_inc;
        o_far_errored_block_count  <= far_cnt_reg + far_inc;
        o_near_defect_second       <= near_ds_reg | ais_raw;
        o_far_defect_second        <= far_ds_reg | rdi_raw;
      end
    end else begin
      o_pm_valid   <= 1'b0;
      near_cnt_reg <= near_cnt_reg + near_inc;
      far_cnt_reg  <= far_cnt_reg + far_inc;
      near_ds_reg  <= near_ds_reg | ais_raw;
      far_ds_reg   <= far_ds_reg | rdi_raw;
    end
  end
endmodule // ssoh_top

// File: ssoh_defines.vh
// constants for the sub-stm-1 multiplex section overhead block
`ifndef SSOH_DEFINES_VH
`define SSOH_DEFINES_VH
// frame geometry, 9 rows of 90 bytes
`define SSOH_LAST_ROW   4'h8
`define SSOH_LAST_COL   7'h59
`define SSOH_SOH_COLS   7'h03
`define SSOH_RS_ROWS    4'h3
// byte position codes inside the section overhead
`define SSOH_POS_NONE   4'h0
`define SSOH_POS_A1     4'h1
`define SSOH_POS_A2     4'h2
`define SSOH_POS_J0     4'h3
`define SSOH_POS_RSOH   4'h4
`define SSOH_POS_B2     4'h5
`define SSOH_POS_K1     4'h6
`define SSOH_POS_K2     4'h7
`define SSOH_POS_S1     4'h8
`define SSOH_POS_M1     4'h9
`define SSOH_POS_E2     4'hA
// overhead byte values
`define SSOH_A1_WORD    8'hF6
`define SSOH_A2_WORD    8'h28
`define SSOH_S1_QL      4'h0
`define SSOH_RDI_CODE   3'h6
`define SSOH_AIS_CODE   3'h7
`define SSOH_REI_MAX    7'h08
// persistence filter length in frames
`define SSOH_PERSIST    3'h5
// one-second counter width, 8000 frames per second fit
`define SSOH_CW         13
// transmit buffer
`define SSOH_BUF_W      9
`endif

// File: ssoh_persist.v
// five-frame persistence filter for a k2 defect pattern
`timescale 1ns/1ns
`include "ssoh_defines.vh"
module ssoh_persist (
  // clock and reset
  input  wire i_clk,
  input  wire i_srst,
  // control and frame samples
  input  wire i_clr,
  input  wire i_frame,
  input  wire i_match,
  // filtered defect
  output reg  o_defect
);
  reg [2:0] cnt_reg;

  // count frames that disagree with the present state, flip at five
  always @(posedge i_clk) begin
    if (i_srst || i_clr) begin
      cnt_reg  <= 3'h0;
      o_defect <= 1'b0;
    end else if (i_frame) begin
      if (i_match != o_defect) begin
        if (cnt_reg == `SSOH_PERSIST - 3'h1) begin
          o_defect <= ~o_defect;
          cnt_reg  <= 3'h0;
        end else begin
          cnt_reg <= cnt_reg + 3'h1;
        end
      end else begin
        cnt_reg <= 3'h0; // a break in the run starts it again
      end
    end
  end
endmodule // ssoh_persist

// File: ssoh_buf2.v
// two-entry buffer with valid and ready on both sides
`timescale 1ns/1ns
`include "ssoh_defines.vh"
module ssoh_buf2 (
  // clock and reset
  input  wire                   i_clk,
  input  wire                   i_srst,
  // fill side
  input  wire                   i_valid,
  output wire                   o_ready,
  input  wire [`SSOH_BUF_W-1:0] i_data,
  // drain side
  output wire                   o_valid,
  input  wire                   i_ready,
  output wire [`SSOH_BUF_W-1:0] o_data
);
  reg [`SSOH_BUF_W-1:0] mem_reg [0:1];
  reg                   wr_reg;
  reg                   rd_reg;
  reg [1:0]             cnt_reg;
  wire                  push;
  wire                  pop;

  // full and empty straight from the occupancy count
  assign o_ready = (cnt_reg != 2'h2);
  assign o_valid = (cnt_reg != 2'h0);
  assign o_data  = mem_reg[rd_reg];
  assign push    = i_valid & o_ready;
  assign pop     = o_valid & i_ready;

  // storage and pointers
  always @(posedge i_clk) begin
    if (i_srst) begin
      wr_reg     <= 1'b0;
      rd_reg     <= 1'b0;
      cnt_reg    <= 2'h0;
      mem_reg[0] <= {`SSOH_BUF_W{1'b0}};
      mem_reg[1] <= {`SSOH_BUF_W{1'b0}};
    end else begin
      if (push) begin
        mem_reg[wr_reg] <= i_data;
        wr_reg          <= ~wr_reg;
      end
      if (pop)
        rd_reg <= ~rd_reg;
      if (push && !pop)
        cnt_reg <= cnt_reg + 2'h1;
      else if (pop && !push)
        cnt_reg <= cnt_reg - 2'h1;
    end
  end
endmodule // ssoh_buf2

// File: ssoh_checker.sv
// port assertions for the overhead block
`timescale 1ns/1ns
`include "ssoh_defines.vh"
module ssoh_checker (
  // clock and reset
  input wire                i_clk,
  input wire                i_srst,
  // controls
  input wire                i_monitored,
  input wire                i_unidir,
  input wire                i_sec_tick,
  // transmit handshake
  input wire                o_tx_ready,
  input wire                o_txo_valid,
  input wire                i_txo_ready,
  input wire [7:0]          o_txo_data,
  input wire                o_txo_sof,
  // defects and report
  input wire                o_remote_defect,
  input wire                o_alarm_defect,
  input wire                o_pm_valid,
  input wire [`SSOH_CW-1:0] o_near_errored_block_count,
  input wire [`SSOH_CW-1:0] o_far_errored_block_count,
  input wire                o_near_defect_second,
  input wire                o_far_defect_second
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_srst);
  // tick that must yield a report
  wire tick_mon = i_sec_tick && i_monitored;
  sequence s_tick_alone;
    tick_mon ##1 !tick_mon;
  endsequence
  sequence s_report;
    o_pm_valid ##1 !o_pm_valid;
  endsequence
  rst_clear_a: assert property (disable iff (1'h0)
    i_srst |=> !o_txo_valid && o_tx_ready && !o_pm_valid)
    else $error("outputs not cleared by reset");
  pm_report_a: assert property (s_tick_alone |-> s_report)
    else $error("report pulse missing or too long");
  pm_quiet_a: assert property (!tick_mon |=> !o_pm_valid)
    else $error("report pulse without monitored tick");
  pm_hold_a: assert property (!tick_mon |=>
    $stable(o_near_errored_block_count) && $stable(o_far_errored_block_count)
    && $stable(o_near_defect_second) && $stable(o_far_defect_second))
    else $error("report changed without monitored tick");
  unmon_quiet_a: assert property (!i_monitored |->
    !o_remote_defect && !o_alarm_defect)
    else $error("defect shown while unmonitored");
  unidir_nordi_a: assert property (
    i_unidir && $past(i_unidir) |-> !o_remote_defect)
    else $error("remote defect in one-way mode");
  out_hold_a: assert property (o_txo_valid && !i_txo_ready |=>
    o_txo_valid && $stable(o_txo_data) && $stable(o_txo_sof))
    else $error("stalled output word changed");
  full_refuse_a: assert property (!o_tx_ready |-> o_txo_valid)
    else $error("input refused with nothing buffered");
  frame_word_a: assert property (o_txo_valid && o_txo_sof |->
    o_txo_data == `SSOH_A1_WORD)
    else $error("frame start word wrong");
  full_seen_c: cover property (!o_tx_ready);
endmodule // ssoh_checker

// File: ssoh_far_model.sv
// far end: receive frame source and transmit sink
`timescale 1ns/1ns
module ssoh_far_model (
  // clock and reset
  input  wire       i_clk,
  input  wire       i_srst,
  // frame content
  input  wire [2:0] i_k2,
  input  wire [6:0] i_m1,
  input  wire [7:0] i_flip,
  input  wire       i_stall,
  // receive stream
  output wire       o_rx_valid,
  output wire [7:0] o_rx_data,
  output wire       o_rx_sof,
  // transmit sink
  output wire       o_txo_ready
);
  reg  [9:0] pos_reg;
  reg  [7:0] fr_reg;
  reg  [7:0] par_reg;
  reg  [7:0] prev_reg;
  reg  [1:0] cyc_reg;
  reg  [7:0] byte_w;
  wire       rs_soh = pos_reg < 10'h10E && pos_reg % 10'h05A < 10'h003;
  wire [7:0] acc_w = par_reg ^ (rs_soh ? 8'h00 : byte_w);
  // overhead over a changing filler, so ignored bits really move
  always @* begin
    byte_w = pos_reg[7:0] ^ fr_reg;
    if (pos_reg == 10'h168)
      byte_w = prev_reg ^ i_flip;
    if (pos_reg == 10'h16A)
      byte_w = {fr_reg[4:0], i_k2};
    if (pos_reg == 10'h2D1)
      byte_w = {fr_reg[0], i_m1};
  end
  // one byte per cycle, parity of rows 0..2 soh left out
  always @(posedge i_clk) begin
    cyc_reg <= i_srst ? 2'h0 : cyc_reg + 2'h1;
    if (i_srst) begin
      pos_reg  <= 10'h000;
      fr_reg   <= 8'h00;
      par_reg  <= 8'h00;
      prev_reg <= 8'h00;
    end else if (pos_reg == 10'h329) begin
      pos_reg  <= 10'h000;
      fr_reg   <= fr_reg + 8'h01;
      par_reg  <= 8'h00;
      prev_reg <= acc_w;
    end else begin
      pos_reg <= pos_reg + 10'h001;
      par_reg <= acc_w;
    end
  end
  assign o_rx_valid  = !i_srst;
  assign o_rx_data   = byte_w;
  assign o_rx_sof    = pos_reg == 10'h000;
  // takes three words in four, so the buffer keeps refusing
  assign o_txo_ready = !i_stall && cyc_reg != 2'h0;
endmodule // ssoh_far_model

// File: ssoh_top_test.sv
// self-checking bench for the overhead block
`timescale 1ns/1ns
`include "ssoh_defines.vh"
module ssoh_top_test;
  typedef struct packed {
    logic        mon;
    logic        uni;
    logic [2:0]  k2;
    logic [6:0]  m1;
    logic [7:0]  flip;
    logic        rdi;
    logic        ais;
    logic [12:0] near;
    logic [12:0] far;
    logic        nds;
    logic        fds;
  } ssoh_row_t;
  localparam [127:0] TRACE = 128'h00112233445566778899AABBCCDDEEFF;
  logic       i_clk = 1'h0, i_srst = 1'h1, i_monitored = 1'h0;
  logic       i_unidir = 1'h0, i_sec_tick = 1'h0, i_tx_valid = 1'h0;
  logic       i_tx_sof = 1'h0, stall = 1'h1, tx_run = 1'h0, win = 1'h0;
  logic [7:0] i_tx_data = 8'h00, flip = 8'h00, exp_m1 = 8'h00;
  logic [7:0] par = 8'h00, prev_par = 8'h00, want;
  logic [6:0] m1 = 7'h00;
  logic [2:0] k2 = 3'h0;
  logic [1:0] prev_def = 2'h0;
  logic       took = 1'h0;
  wire        o_tx_ready, o_txo_valid, i_txo_ready, o_txo_sof, i_rx_valid;
  wire        i_rx_sof, o_remote_defect, o_alarm_defect, o_pm_valid;
  wire        o_nds, o_fds;
  wire [7:0]  o_txo_data, i_rx_data;
  wire [12:0] o_near, o_far;
  integer     error_cnt = 0, checked = 0, cycles = 0, r, row, col;
  integer     tx_pos = 0, tx_fr = 0, mo_pos = 0, mo_fr = 0;
  ssoh_row_t  rows [6];
  ssoh_top i_dut (.i_clk(i_clk), .i_srst(i_srst), .i_monitored(i_monitored),
    .i_unidir(i_unidir), .i_sec_tick(i_sec_tick),
    .i_trail_trace_identifier(TRACE), .i_tx_valid(i_tx_valid),
    .o_tx_ready(o_tx_ready), .i_tx_data(i_tx_data), .i_tx_sof(i_tx_sof),
    .o_txo_valid(o_txo_valid), .i_txo_ready(i_txo_ready),
    .o_txo_data(o_txo_data), .o_txo_sof(o_txo_sof), .i_rx_valid(i_rx_valid),
    .i_rx_data(i_rx_data), .i_rx_sof(i_rx_sof),
    .o_remote_defect(o_remote_defect), .o_alarm_defect(o_alarm_defect),
    .o_pm_valid(o_pm_valid), .o_near_errored_block_count(o_near),
    .o_far_errored_block_count(o_far), .o_near_defect_second(o_nds),
    .o_far_defect_second(o_fds));
  ssoh_far_model i_far (.i_clk(i_clk), .i_srst(i_srst), .i_k2(k2),
    .i_m1(m1), .i_flip(flip), .i_stall(stall), .o_rx_valid(i_rx_valid),
    .o_rx_data(i_rx_data), .o_rx_sof(i_rx_sof), .o_txo_ready(i_txo_ready));
  always #50 i_clk = ~i_clk;
  function automatic [7:0] pat(input integer f, input integer p);
    pat = p[7:0] + f[7:0] * 8'h03;
  endfunction
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp_v);
    checked = checked + 1;
    if (seen !== exp_v) begin
      error_cnt = error_cnt + 1;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp_v);
    end
  endtask
  task finish_test;
    if (error_cnt == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // frame starts are seen where the start byte is taken
  task wait_frames(input integer n);
    repeat (n) begin
      @(posedge i_clk);
      while (i_rx_sof !== 1'h1)
        @(posedge i_clk);
    end
  endtask
  // hang guard, the run needs about 25000 cycles
  always @(posedge i_clk) begin
    cycles = cycles + 1;
    if (cycles == 40000) begin
      error_cnt = error_cnt + 1;
      finish_test;
    end
  end
  // source keeps a word up until taken, then moves on
  always @(posedge i_clk) begin
    took = i_tx_valid && o_tx_ready;
    if (took) begin
      tx_pos = tx_pos == 809 ? 0 : tx_pos + 1;
      tx_fr = tx_pos == 0 ? tx_fr + 1 : tx_fr;
    end
    #1;
    // a word not taken at this edge stays up, even when stopping
    i_tx_valid = tx_run || (i_tx_valid && !took);
    i_tx_data = pat(tx_fr, tx_pos);
    i_tx_sof = tx_pos == 0;
  end
  // output monitor: position, parity and overwritten bytes
  always @(posedge i_clk) begin
    if (o_txo_valid && i_txo_ready) begin
      row = mo_pos / 90;
      col = mo_pos % 90;
      want = pat(mo_fr, mo_pos);
      case (mo_pos)
        0: want = `SSOH_A1_WORD;
        1: want = `SSOH_A2_WORD;
        2: want = TRACE[127 - 8 * (mo_fr % 16) -: 8];
        360: want = mo_fr == 0 ? 8'h00 : prev_par;
        720: want = {want[7:4], `SSOH_S1_QL};
        721: want = win ? exp_m1 : o_txo_data;
        default: ;
      endcase
      chk(o_txo_data, want);
      chk(o_txo_sof, mo_pos == 0);
      if (!(row < 3 && col < 3))
        par = par ^ o_txo_data;
      mo_pos = mo_pos == 809 ? 0 : mo_pos + 1;
      if (mo_pos == 0) begin
        prev_par = par;
        par = 8'h00;
        mo_fr = mo_fr + 1;
      end
    end
  end
  initial begin
    rows[0] = '{1'h1, 1'h0, 3'h0, 7'h00, 8'h00, 1'h0, 1'h0, 13'h0, 13'h0, 1'h0, 1'h0};
    rows[1] = '{1'h1, 1'h0, 3'h6, 7'h03, 8'h01, 1'h1, 1'h0, 13'h5, 13'h5, 1'h0, 1'h1};
    rows[2] = '{1'h1, 1'h0, 3'h7, 7'h09, 8'hFF, 1'h0, 1'h1, 13'h5, 13'h0, 1'h1, 1'h1};
    rows[3] = '{1'h1, 1'h0, 3'h0, 7'h08, 8'h00, 1'h0, 1'h0, 13'h0, 13'h5, 1'h1, 1'h0};
    rows[4] = '{1'h1, 1'h1, 3'h6, 7'h02, 8'h02, 1'h0, 1'h0, 13'h5, 13'h0, 1'h0, 1'h0};
    rows[5] = '{1'h0, 1'h0, 3'h7, 7'h01, 8'h00, 1'h0, 1'h0, 13'h5, 13'h0, 1'h0, 1'h0};
    repeat (4) @(posedge i_clk);
    #1;
    chk({o_tx_ready, o_txo_valid, o_pm_valid}, 3'h4);
    i_srst = 1'h0;
    tx_run = 1'h1;
    repeat (5) @(posedge i_clk);
    #1;
    chk({o_tx_ready, o_txo_valid}, 2'h1); // sink stalled, buffer full
    stall = 1'h0;
    wait_frames(1);
    // one row per second: four frames keep the old defect, five switch it
    for (r = 0; r < 6; r = r + 1) begin
      #1;
      {i_monitored, i_unidir, k2, m1, flip} = rows[r][49:30];
      win = 1'h0;
      exp_m1 = rows[r].uni ? 8'h00 : $countones(rows[r].flip);
      wait_frames(1);
      #1;
      win = 1'h1;
      wait_frames(3);
      #1;
      chk({o_remote_defect, o_alarm_defect}, prev_def);
      wait_frames(1);
      #1;
      i_sec_tick = 1'h1;
      prev_def = {rows[r].rdi, rows[r].ais};
      chk({o_remote_defect, o_alarm_defect}, prev_def);
      @(posedge i_clk);
      #1;
      i_sec_tick = 1'h0;
      chk(o_pm_valid, rows[r].mon);
      chk(o_near, rows[r].near);
      chk(o_far, rows[r].far);
      chk({o_nds, o_fds}, {rows[r].nds, rows[r].fds});
    end
    // drain: source stops, buffer must empty
    tx_run = 1'h0;
    repeat (8) @(posedge i_clk);
    #1;
    chk({o_txo_valid, o_tx_ready}, 2'h1);
    finish_test;
  end
endmodule // ssoh_top_test
bind ssoh_top ssoh_checker i_chk (.i_clk(i_clk), .i_srst(i_srst),
  .i_monitored(i_monitored), .i_unidir(i_unidir), .i_sec_tick(i_sec_tick),
  .o_tx_ready(o_tx_ready), .o_txo_valid(o_txo_valid),
  .i_txo_ready(i_txo_ready), .o_txo_data(o_txo_data), .o_txo_sof(o_txo_sof),
  .o_remote_defect(o_remote_defect), .o_alarm_defect(o_alarm_defect),
  .o_pm_valid(o_pm_valid),
  .o_near_errored_block_count(o_near_errored_block_count),
  .o_far_errored_block_count(o_far_errored_block_count),
  .o_near_defect_second(o_near_defect_second),
  .o_far_defect_second(o_far_defect_second));
